// *** rtl/otg_regs_pkg.sv ***
// Constants, field positions and carriers for the Otg_line_control and event registers.
package otg_regs_pkg;

    // Register addresses, as six-bit command addresses.
    localparam logic [5:0] ADDR_OTG_LINE_CONTROL = 6'h0a;
    localparam logic [5:0] ADDR_RISING_ENABLE = 6'h0d;
    localparam logic [5:0] ADDR_FALLING_ENABLE = 6'h10;
    localparam logic [5:0] ADDR_LIVE_STATUS = 6'h13;
    localparam logic [5:0] ADDR_LATCHED_STATUS = 6'h14;

    // Offsets of the write, set and clear aliases from a group base.
    localparam logic [5:0] ALIAS_WRITE_OFS = 6'h00;
    localparam logic [5:0] ALIAS_SET_OFS = 6'h01;
    localparam logic [5:0] ALIAS_CLEAR_OFS = 6'h02;

    // Field positions of the OTG line control byte.
    localparam int BIT_ID_PULL_UP = 0;
    localparam int BIT_PLUS_PULL_DOWN = 1;
    localparam int BIT_MINUS_PULL_DOWN = 2;
    localparam int BIT_DISCHARGE = 3;
    localparam int BIT_CHARGE = 4;
    localparam int BIT_SUPPLY_DRIVE = 5;
    localparam int BIT_SUPPLY_DRIVE_ALT = 6;
    localparam int BIT_EXT_INDICATOR_SEL = 7;

    // Field positions of the monitored lines in enable and status bytes.
    localparam int BIT_HOST_DISCONNECT = 0;
    localparam int BIT_POWER_VALID = 1;
    localparam int BIT_SESSION_VALID = 2;
    localparam int BIT_SESSION_END = 3;
    localparam int BIT_ID_GROUNDED = 4;
    localparam int LINE_COUNT = 5;

    // Values after reset.
    localparam logic [7:0] RESET_OTG_LINE_CONTROL = 8'h06;
    localparam logic [4:0] RESET_EVENT_ENABLE = 5'h1f;
    localparam logic [4:0] RESET_LATCHED = 5'h00;
    localparam logic [7:0] RESET_READ_DATA = 8'h00;

    // Synchroniser depth for pin inputs.
    localparam int SYNC_STAGES = 2;

    // Kind of access decoded from an address within an aliased group.
    typedef enum logic [1:0] {ACC_NONE, ACC_WRITE, ACC_SET, ACC_CLEAR} access_e;

    // One register command as delivered by the interface front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Answer to a register read.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_rsp_s;

endpackage : otg_regs_pkg

// *** rtl/line_level_sync.sv ***
// Two-stage synchroniser for the analog comparator and pin levels.
`timescale 1ns/10ps
module line_level_sync
    import otg_regs_pkg::*;
#(
    parameter int WIDTH = 6
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Levels from outside the clock domain
    input wire logic [WIDTH-1:0] raw_levels,
    // Levels safe to use in the clock domain
    output logic [WIDTH-1:0] sync_levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= '0;
            stable_q <= '0;
        end
        else
        begin
            meta_q <= raw_levels;
            stable_q <= meta_q;
        end
    end

    assign sync_levels = stable_q;

endmodule : line_level_sync

// *** rtl/otg_line_control_and_event_registers.sv ***
// OTG line control, edge event enables, live and latched line status registers.
//
// How it works
// - Otg_line_control readable thrice; write, set, clear.
// - Bit 0 drives ID pull-up, resets zero.
// - Bit 1 drives plus-line pull-down, resets one.
// - Bit 2 drives minus-line pull-down, resets one.
// - Bit 3 drives bus discharge path, resets zero.
// - Bit 4 drives bus charge path, resets zero.
// - Supply drive output is OR of bits 5,6.
// - Bit 7 selects external power-valid indicator.
// - Rising enable byte with write, set, clear.
// - Enabled low-to-high changes raise events; reset set.
// - Falling enable byte with write, set, clear.
// - Enabled high-to-low changes raise events; reset set.
// - Host-disconnect events only in host mode.
// - Live status byte is read-only.
// - Live status shows five levels, upper zero.
// - Host-disconnect status meaningful only in host mode.
// - Events set latched byte; read clears it.
`timescale 1ns/10ps
module otg_line_control_and_event_registers
    import otg_regs_pkg::*;
#(
    parameter int LINES = LINE_COUNT
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,

    // Register commands from the interface front end
    input wire reg_req_s reg_req,
    output reg_rsp_s reg_rsp,

    // Operating mode from logic on the same clock
    input wire logic host_mode,

    // Analog comparator levels and pins
    input wire logic host_disconnect_level,
    input wire logic internal_power_valid_level,
    input wire logic external_power_indicator_input,
    input wire logic session_valid_level,
    input wire logic session_end_level,
    input wire logic id_pin_grounded,

    // Analog switch controls
    output logic id_pin_pull_up_enable,
    output logic plus_line_pull_down_enable,
    output logic minus_line_pull_down_enable,
    output logic bus_power_discharge_enable,
    output logic bus_power_charge_enable,
    output logic bus_power_supply_enable,

    // Event notification towards the interface front end
    output logic line_event_pending
);

    // Decodes which alias of a three-address group an address hits.
    function automatic access_e decode_alias(input logic [5:0] addr, input logic [5:0] base);
        access_e kind;
        kind = ACC_NONE;
        if (addr == base + ALIAS_WRITE_OFS)
        begin
            kind = ACC_WRITE;
        end
        else if (addr == base + ALIAS_SET_OFS)
        begin
            kind = ACC_SET;
        end
        else if (addr == base + ALIAS_CLEAR_OFS)
        begin
            kind = ACC_CLEAR;
        end
        return kind;
    endfunction : decode_alias

    // Applies a plain, set or clear write to a stored value.
    function automatic logic [7:0] apply_write(input logic [7:0] cur, input logic [7:0] wdata,
                                               input access_e kind);
        logic [7:0] nxt;
        nxt = cur;
        unique case (kind)
            ACC_NONE: nxt = cur;
            ACC_WRITE: nxt = wdata;
            ACC_SET: nxt = cur | wdata;
            ACC_CLEAR: nxt = cur & ~wdata;
        endcase
        return nxt;
    endfunction : apply_write

    // Stored registers.
    logic [7:0] otg_line_control_q;
    logic [7:0] otg_line_control_d;
    logic [LINES-1:0] rise_enable_q;
    logic [LINES-1:0] fall_enable_q;
    logic [LINES-1:0] latched_q;
    logic [LINES-1:0] latched_d;
    logic [LINES-1:0] levels_prev_q;
    logic supply_enable_q;
    logic pending_q;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;

    // Decoded accesses.
    access_e otg_kind;
    access_e rise_kind;
    access_e fall_kind;
    logic [7:0] rise_next;
    logic [7:0] fall_next;

    // Synchronised pin levels and the monitored line vector.
    logic [5:0] raw_pins;
    logic [5:0] pin_levels;
    logic power_valid_selected;
    logic [LINES-1:0] line_levels;
    logic [LINES-1:0] rise_events;
    logic [LINES-1:0] fall_events;
    logic [LINES-1:0] line_events;
    logic [LINES-1:0] mode_mask;
    logic [7:0] live_status;
    logic [7:0] read_value;

    assign raw_pins = {external_power_indicator_input, id_pin_grounded, session_end_level,
                       session_valid_level, internal_power_valid_level,
                       host_disconnect_level};

    line_level_sync #(
        .WIDTH(6)
    ) u_line_level_sync (
        .core_clk(core_clk),
        .reset(reset),
        .raw_levels(raw_pins),
        .sync_levels(pin_levels)
    );

    // Choose internal comparator or external indicator as power valid.
    assign power_valid_selected = otg_line_control_q[BIT_EXT_INDICATOR_SEL] ? pin_levels[5]
                                                                        : pin_levels[1];

    always_comb
    begin
        line_levels = pin_levels[LINES-1:0];
        line_levels[BIT_POWER_VALID] = power_valid_selected;
    end

    // Host disconnect only counts while in host mode.
    always_comb
    begin
        mode_mask = '1;
        mode_mask[BIT_HOST_DISCONNECT] = host_mode;
    end

    // Edge detection against the previous sampled level.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            levels_prev_q <= '0;
        end
        else
        begin
            levels_prev_q <= line_levels;
        end
    end

    assign rise_events = line_levels & ~levels_prev_q & rise_enable_q & mode_mask;
    assign fall_events = ~line_levels & levels_prev_q & fall_enable_q & mode_mask;
    assign line_events = rise_events | fall_events;

    // Address decode for the three aliased groups.
    assign otg_kind = reg_req.wr ? decode_alias(reg_req.addr, ADDR_OTG_LINE_CONTROL)
                                 : ACC_NONE;
    assign rise_kind = reg_req.wr ? decode_alias(reg_req.addr, ADDR_RISING_ENABLE)
                                  : ACC_NONE;
    assign fall_kind = reg_req.wr ? decode_alias(reg_req.addr, ADDR_FALLING_ENABLE)
                                  : ACC_NONE;

    assign otg_line_control_d = apply_write(otg_line_control_q, reg_req.wdata, otg_kind);
    assign rise_next = apply_write({3'h0, rise_enable_q}, reg_req.wdata, rise_kind);
    assign fall_next = apply_write({3'h0, fall_enable_q}, reg_req.wdata, fall_kind);

    // OTG line control byte.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            otg_line_control_q <= RESET_OTG_LINE_CONTROL;
        end
        else
        begin
            otg_line_control_q <= otg_line_control_d;
        end
    end

    // Supply drive combines the two drive bits into one registered output.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            supply_enable_q <= 1'b0;
        end
        else
        begin
            supply_enable_q <= otg_line_control_d[BIT_SUPPLY_DRIVE]
                               | otg_line_control_d[BIT_SUPPLY_DRIVE_ALT];
        end
    end

    // Rising edge event enables; reserved upper bits are not stored.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rise_enable_q <= RESET_EVENT_ENABLE;
        end
        else
        begin
            rise_enable_q <= rise_next[LINES-1:0];
        end
    end

    // Falling edge event enables; reserved upper bits are not stored.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            fall_enable_q <= RESET_EVENT_ENABLE;
        end
        else
        begin
            fall_enable_q <= fall_next[LINES-1:0];
        end
    end

    // Latched events: a new event wins over the clear caused by a read.
    always_comb
    begin
        latched_d = latched_q;
        if (reg_req.rd && reg_req.addr == ADDR_LATCHED_STATUS)
        begin
            latched_d = '0;
        end
        latched_d = latched_d | line_events;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            latched_q <= RESET_LATCHED;
        end
        else
        begin
            latched_q <= latched_d;
        end
    end

    // Pending flag follows the next latched byte, so it rises with the latch.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pending_q <= 1'b0;
        end
        else
        begin
            pending_q <= |latched_d;
        end
    end

    // Live status shows current levels; writes to it have no target.
    always_comb
    begin
        live_status = 8'h00;
        live_status[LINES-1:0] = line_levels & mode_mask;
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb
    begin
        read_value = 8'h00;
        if (decode_alias(reg_req.addr, ADDR_OTG_LINE_CONTROL) != ACC_NONE)
        begin
            read_value = otg_line_control_q;
        end
        else if (decode_alias(reg_req.addr, ADDR_RISING_ENABLE) != ACC_NONE)
        begin
            read_value = {3'h0, rise_enable_q};
        end
        else if (decode_alias(reg_req.addr, ADDR_FALLING_ENABLE) != ACC_NONE)
        begin
            read_value = {3'h0, fall_enable_q};
        end
        else if (reg_req.addr == ADDR_LIVE_STATUS)
        begin
            read_value = live_status;
        end
        else if (reg_req.addr == ADDR_LATCHED_STATUS)
        begin
            read_value = {3'h0, latched_q};
        end
    end

    // Read answer flag, registered one cycle after the request.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_valid_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q <= reg_req.rd;
        end
    end

    // Read data is captured on a read and held until the next one.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_data_q <= RESET_READ_DATA;
        end
        else if (reg_req.rd)
        begin
            rsp_data_q <= read_value;
        end
    end

    // Outputs straight from flip-flops.
    assign reg_rsp = {rsp_valid_q, rsp_data_q};
    assign id_pin_pull_up_enable = otg_line_control_q[BIT_ID_PULL_UP];
    assign plus_line_pull_down_enable = otg_line_control_q[BIT_PLUS_PULL_DOWN];
    assign minus_line_pull_down_enable = otg_line_control_q[BIT_MINUS_PULL_DOWN];
    assign bus_power_discharge_enable = otg_line_control_q[BIT_DISCHARGE];
    assign bus_power_charge_enable = otg_line_control_q[BIT_CHARGE];
    assign bus_power_supply_enable = supply_enable_q;
    assign line_event_pending = pending_q;

endmodule : otg_line_control_and_event_registers

// *** tb/otg_regs_assertions.sv ***
// Port-level assertions for the Otg_line_control and event registers.
`timescale 1ns/10ps
module otg_regs_assertions
    import otg_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire reg_req_s reg_req,
    input wire reg_rsp_s reg_rsp,
    // Switch controls and event flag
    input wire logic id_pin_pull_up_enable,
    input wire logic plus_line_pull_down_enable,
    input wire logic minus_line_pull_down_enable,
    input wire logic bus_power_discharge_enable,
    input wire logic bus_power_charge_enable,
    input wire logic bus_power_supply_enable,
    input wire logic line_event_pending
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    logic [5:0] outs;
    logic ctrl_wr;
    assign outs = {bus_power_supply_enable, bus_power_charge_enable, bus_power_discharge_enable,
        minus_line_pull_down_enable, plus_line_pull_down_enable, id_pin_pull_up_enable};
    assign ctrl_wr = reg_req.wr && reg_req.addr inside {[6'h0a:6'h0c]};

    a_read_answer: assert property (reg_req.rd |=> reg_rsp.valid)
        else $error("read got no answer");
    a_no_spurious: assert property (!reg_req.rd |=> !reg_rsp.valid)
        else $error("answer without read");
    a_plain_write: assert property (reg_req.wr && reg_req.addr == 6'h0a
        |=> outs == {$past(reg_req.wdata[5]) | $past(reg_req.wdata[6]), $past(reg_req.wdata[4:0])})
        else $error("plain write not applied");
    a_set_alias: assert property (reg_req.wr && reg_req.addr == 6'h0b && reg_req.wdata[0]
        |=> id_pin_pull_up_enable) else $error("set alias failed");
    a_clear_alias: assert property (reg_req.wr && reg_req.addr == 6'h0c && reg_req.wdata[1]
        |=> !plus_line_pull_down_enable) else $error("clear alias failed");
    a_ctrl_stable: assert property (!ctrl_wr |=> $stable(outs))
        else $error("controls changed without write");
    a_upper_zero: assert property (reg_req.rd && reg_req.addr inside {[6'h0d:6'h13]}
        |=> reg_rsp.data[7:5] == 3'h0) else $error("reserved bits set");
    a_unmapped_zero: assert property (reg_req.rd && reg_req.addr inside {[6'h15:6'h3f]}
        |=> reg_rsp.data == 8'h00) else $error("unmapped read not zero");
    a_pending_holds: assert property (line_event_pending && !(reg_req.rd && reg_req.addr == 6'h14)
        |=> line_event_pending) else $error("pending dropped");
endmodule : otg_regs_assertions

bind otg_line_control_and_event_registers otg_regs_assertions u_otg_regs_assertions (
    .core_clk(core_clk), .reset(reset), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .id_pin_pull_up_enable(id_pin_pull_up_enable),
    .plus_line_pull_down_enable(plus_line_pull_down_enable),
    .minus_line_pull_down_enable(minus_line_pull_down_enable),
    .bus_power_discharge_enable(bus_power_discharge_enable),
    .bus_power_charge_enable(bus_power_charge_enable),
    .bus_power_supply_enable(bus_power_supply_enable),
    .line_event_pending(line_event_pending));

// *** tb/link_port_model.sv ***
// Behavioural link controller issuing register commands.
`timescale 1ns/10ps
module link_port_model
    import otg_regs_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register port
    output reg_req_s reg_req,
    input wire reg_rsp_s reg_rsp
);
    initial
    begin
        reg_req = '0;
    end

    // Released address and data show the inverse of their last value; wr and rd go low.
    task automatic release_bus();
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask : release_bus

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(negedge core_clk);
        release_bus();
    endtask : wr_reg

    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(negedge core_clk);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(negedge core_clk);
        ok = (reg_rsp.valid === 1'b1);
        d = reg_rsp.data;
        release_bus();
    endtask : rd_reg
endmodule : link_port_model

// *** tb/otg_line_control_and_event_registers_tb.sv ***
// Self-checking bench for the Otg_line_control and event registers.
`timescale 1ns/10ps
module otg_line_control_and_event_registers_tb
    import otg_regs_pkg::*;
;
    logic core_clk;
    logic reset;
    logic host_mode;
    logic [5:0] lv;
    reg_req_s reg_req;
    reg_rsp_s reg_rsp;
    logic [5:0] outs;
    logic pend;
    logic [7:0] exp[3];
    logic [7:0] e;
    logic [7:0] m;
    integer seed;
    int bad_count;
    int n_compared;
    logic [5:0] base[3] = '{6'h0a, 6'h0d, 6'h10};
    logic [7:0] mask[3] = '{8'hff, 8'h1f, 8'h1f};

    link_port_model u_link_port_model (.core_clk(core_clk), .reg_req(reg_req),
        .reg_rsp(reg_rsp));
    otg_line_control_and_event_registers u_otg_line_control_and_event_registers (
        .core_clk(core_clk), .reset(reset), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .host_mode(host_mode), .host_disconnect_level(lv[0]),
        .internal_power_valid_level(lv[1]), .session_valid_level(lv[2]),
        .session_end_level(lv[3]), .id_pin_grounded(lv[4]),
        .external_power_indicator_input(lv[5]),
        .id_pin_pull_up_enable(outs[0]), .plus_line_pull_down_enable(outs[1]),
        .minus_line_pull_down_enable(outs[2]), .bus_power_discharge_enable(outs[3]),
        .bus_power_charge_enable(outs[4]), .bus_power_supply_enable(outs[5]),
        .line_event_pending(pend));

    function automatic logic [5:0] outs_exp(input logic [7:0] c);
        return {c[5] | c[6], c[4:0]};
    endfunction : outs_exp

    function automatic logic [7:0] status_exp(input logic [5:0] l, input logic h,
        input logic sel);
        return {3'h0, l[4:2], sel ? l[5] : l[1], h & l[0]};
    endfunction : status_exp

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic check8(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want)
        begin
            bad_count++;
            $display("MISMATCH %0t value %h expected %h", $time, got, want);
        end
    endtask : check8

    task automatic rdc(input logic [5:0] a, input logic [7:0] want);
        logic [7:0] d;
        logic ok;
        u_link_port_model.rd_reg(a, d, ok);
        check8({7'h00, ok}, 8'h01);
        check8(d, want);
    endtask : rdc

    // Writes one alias, updates the model and reads back all three aliases.
    task automatic wr_chk(input int b, input int ofs, input logic [7:0] d);
        u_link_port_model.wr_reg(base[b] + 6'(ofs), d);
        exp[b] = ofs == 0 ? d & mask[b] : ofs == 1 ? exp[b] | (d & mask[b]) : exp[b] & ~d;
        if (b == 0)
            check8({2'h0, outs}, {2'h0, outs_exp(exp[0])});
        for (int k = 0; k < 3; k++)
            rdc(base[b] + 6'(k), exp[b]);
    endtask : wr_chk

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        reset = 1'b1;
        host_mode = 1'b0;
        lv = 6'h00;
        bad_count = 0;
        n_compared = 0;
        seed = 32'h6e2aa3d1;
        exp = '{8'h06, 8'h1f, 8'h1f};
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        check8({2'h0, outs}, 8'h06);
        for (int b = 0; b < 3; b++)
            for (int k = 0; k < 3; k++)
                rdc(base[b] + 6'(k), exp[b]);
        for (int b = 0; b < 3; b++)
            for (int n = 0; n < 4; n++)
                for (int ofs = 0; ofs < 3; ofs++)
                begin
                    m = 8'($random(seed));
                    wr_chk(b, ofs, m);
                end
        u_link_port_model.wr_reg(ADDR_LIVE_STATUS, 8'hff);
        rdc(ADDR_LIVE_STATUS, status_exp(lv, host_mode, exp[0][7]));
        rdc(6'h20, 8'h00);
        for (int n = 0; n < 8; n++)
        begin
            m = 8'($random(seed));
            lv = m[5:0];
            host_mode = m[6];
            wr_chk(0, n[0] ? 1 : 2, 8'h80);
            repeat (4) @(negedge core_clk);
            rdc(ADDR_LIVE_STATUS, status_exp(lv, host_mode, exp[0][7]));
        end
        lv = 6'h00;
        wr_chk(0, 2, 8'h80);
        repeat (5) @(negedge core_clk);
        u_link_port_model.rd_reg(ADDR_LATCHED_STATUS, e, m[0]);
        for (int h = 0; h < 2; h++)
            for (int p = 0; p < 2; p++)
                for (int i = 0; i < 5; i++)
                begin
                    host_mode = h[0];
                    u_link_port_model.wr_reg(ADDR_RISING_ENABLE, p ? 8'h00 : 8'h01 << i);
                    u_link_port_model.wr_reg(ADDR_FALLING_ENABLE, p ? 8'h01 << i : 8'h00);
                    for (int v = 1; v >= 0; v--)
                    begin
                        lv[i] = v[0];
                        repeat (5) @(negedge core_clk);
                        e = ((h != 0 || i != 0) && (p != v)) ? 8'h01 << i : 8'h00;
                        check8({7'h00, pend}, {7'h00, e != 8'h00});
                        rdc(ADDR_LATCHED_STATUS, e);
                    end
                end
        summarize();
    end
endmodule : otg_line_control_and_event_registers_tb
